// file: timer_irq_pkg.sv
package timer_irq_pkg;

    localparam int          COUNT_WIDTH_DEFAULT = 16;

    localparam logic [7:0]  ADDR_FLAGS    = 8'h39;
    localparam logic [7:0]  ADDR_MASK     = 8'h72;
    localparam logic [7:0]  ADDR_CNT_LO   = 8'hA4;
    localparam logic [7:0]  ADDR_CNT_HI   = 8'hA5;
    localparam logic [7:0]  ADDR_CAP_LO   = 8'hA6;
    localparam logic [7:0]  ADDR_CAP_HI   = 8'hA7;
    localparam logic [7:0]  ADDR_CMP_A_LO = 8'hA8;
    localparam logic [7:0]  ADDR_CMP_A_HI = 8'hA9;
    localparam logic [7:0]  ADDR_CMP_B_LO = 8'hAA;
    localparam logic [7:0]  ADDR_CMP_B_HI = 8'hAB;
    localparam logic [7:0]  ADDR_CMP_C_LO = 8'hAC;
    localparam logic [7:0]  ADDR_CMP_C_HI = 8'hAD;

    localparam int          BIT_OVERFLOW = 0;
    localparam int          BIT_MATCH_A  = 1;
    localparam int          BIT_MATCH_B  = 2;
    localparam int          BIT_MATCH_C  = 3;
    localparam int          BIT_CAPTURE  = 5;

    localparam logic [7:0]  IRQ_BITS_MASK = 8'h2F;
    localparam logic [7:0]  RESET_BYTE    = 8'h00;
    localparam logic [15:0] RESET_WORD    = 16'h0000;
    localparam logic [15:0] COUNTER_MAX   = 16'hFFFF;

    localparam logic [3:0]  MODE_NORMAL   = 4'h0;
    localparam logic [3:0]  MODE_CLEAR_A  = 4'h4;
    localparam logic [3:0]  MODE_CLEAR_B  = 4'hC;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] data;
    } bus_req_type;

endpackage

// file: timer_compare_irq_regs.sv
`timescale 1ns/1ps
module timer_compare_irq_regs #(
    parameter int COUNT_WIDTH = timer_irq_pkg::COUNT_WIDTH_DEFAULT
) (
    input  wire logic                       i_clk,
    input  wire logic                       i_rst,
    input  wire timer_irq_pkg::bus_req_type i_bus,
    input  wire logic                       i_timer_tick,
    input  wire logic [COUNT_WIDTH-1:0]     i_counter_value,
    input  wire logic [3:0]                 i_waveform_mode_select,
    input  wire logic                       i_pwm_overflow,
    input  wire logic [2:0]                 i_force_match,
    input  wire logic                       i_global_irq_enable,
    input  wire logic [3:0]                 i_vector_ack,
    output logic      [7:0]                 o_rd_data,
    output logic      [3:0]                 o_irq_request,
    output logic      [2:0]                 o_match_event
);
    import timer_irq_pkg::*;

    if (COUNT_WIDTH != 16) begin : g_width_check
        $error("COUNT_WIDTH must be 16: the register pairs are two bytes");
    end

    localparam logic [7:0] CMP_LO_ADDR [3] = '{ADDR_CMP_A_LO, ADDR_CMP_B_LO, ADDR_CMP_C_LO};

    function automatic logic hit_at(input bus_req_type b, input logic strobe,
                                    input logic [7:0] a);
        return strobe && (b.addr == a);
    endfunction

    logic [7:0]  temp_q;
    logic [7:0]  flags_q;
    logic [7:0]  flags_d;
    logic [7:0]  mask_q;
    logic [15:0] capture_q;
    logic [15:0] compare_q [3];
    logic        block_q;
    logic [7:0]  rd_q;
    logic [7:0]  rd_d;
    logic [3:0]  irq_q;
    logic [2:0]  event_q;
    logic [2:0]  match_hit;
    logic        overflow_hit;
    logic        non_pwm;
    logic        cnt_write;
    logic        hi_write;
    logic        cap_lo_read;
    logic [7:0]  set_vec;
    logic [7:0]  clr_vec;

    assign non_pwm = (i_waveform_mode_select == MODE_NORMAL)
                  || (i_waveform_mode_select == MODE_CLEAR_A)
                  || (i_waveform_mode_select == MODE_CLEAR_B);

    assign cnt_write = hit_at(i_bus, i_bus.wr, ADDR_CNT_LO)
                    || hit_at(i_bus, i_bus.wr, ADDR_CNT_HI);
    assign hi_write  = hit_at(i_bus, i_bus.wr, ADDR_CNT_HI)
                    || hit_at(i_bus, i_bus.wr, ADDR_CMP_A_HI)
                    || hit_at(i_bus, i_bus.wr, ADDR_CMP_B_HI)
                    || hit_at(i_bus, i_bus.wr, ADDR_CMP_C_HI);
    assign cap_lo_read = hit_at(i_bus, i_bus.rd, ADDR_CAP_LO);

    // One holding byte is shared by every 16-bit pair of the timer.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            temp_q <= RESET_BYTE;
        end else if (hi_write) begin
            temp_q <= i_bus.data;
        end else if (cap_lo_read) begin
            temp_q <= capture_q[15:8];
        end
    end

    // With no capture input this pair only ever holds its reset value.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            capture_q <= RESET_WORD;
        end else begin
            capture_q <= capture_q;
        end
    end

    // A counter write blocks matches until the next timer tick has passed.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            block_q <= 1'b0;
        end else if (cnt_write) begin
            block_q <= 1'b1;
        end else if (i_timer_tick) begin
            block_q <= 1'b0;
        end
    end

    for (genvar ch = 0; ch < 3; ch++) begin : g_channel
        always_ff @(posedge i_clk) begin
            if (i_rst) begin
                compare_q[ch] <= RESET_WORD;
            end else if (hit_at(i_bus, i_bus.wr, CMP_LO_ADDR[ch])) begin
                compare_q[ch] <= {temp_q, i_bus.data};
            end
        end

        assign match_hit[ch] = i_timer_tick && !block_q
                            && (i_counter_value == compare_q[ch]);

        // Forced strobes act as compare events in the non-waveform modes only, but stay out of the flags.
        always_ff @(posedge i_clk) begin
            if (i_rst) begin
                event_q[ch] <= 1'b0;
            end else begin
                event_q[ch] <= match_hit[ch] || (i_force_match[ch] && non_pwm);
            end
        end
    end

    assign overflow_hit = i_timer_tick
                       && (non_pwm ? (i_counter_value == COUNTER_MAX) : i_pwm_overflow);

    always_comb begin
        set_vec = RESET_BYTE;
        set_vec[BIT_OVERFLOW] = overflow_hit;
        set_vec[BIT_MATCH_A] = match_hit[0];
        set_vec[BIT_MATCH_B] = match_hit[1];
        set_vec[BIT_MATCH_C] = match_hit[2];
        clr_vec = RESET_BYTE;
        if (hit_at(i_bus, i_bus.wr, ADDR_FLAGS)) begin
            clr_vec = i_bus.data & IRQ_BITS_MASK;
        end
        clr_vec[BIT_OVERFLOW] = clr_vec[BIT_OVERFLOW] || i_vector_ack[BIT_OVERFLOW];
        clr_vec[BIT_MATCH_A] = clr_vec[BIT_MATCH_A] || i_vector_ack[BIT_MATCH_A];
        clr_vec[BIT_MATCH_B] = clr_vec[BIT_MATCH_B] || i_vector_ack[BIT_MATCH_B];
        clr_vec[BIT_MATCH_C] = clr_vec[BIT_MATCH_C] || i_vector_ack[BIT_MATCH_C];
        // A new event in the clearing cycle wins over the clear.
        flags_d = ((flags_q & ~clr_vec) | set_vec) & IRQ_BITS_MASK;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            flags_q <= RESET_BYTE;
        end else begin
            flags_q <= flags_d;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mask_q <= RESET_BYTE;
        end else if (hit_at(i_bus, i_bus.wr, ADDR_MASK)) begin
            mask_q <= i_bus.data & IRQ_BITS_MASK;
        end
    end

    // The capture enable and flag are left out of the request gating.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            irq_q <= 4'h0;
        end else begin
            irq_q <= mask_q[3:0] & flags_q[3:0] & {4{i_global_irq_enable}};
        end
    end

    always_comb begin
        case (i_bus.addr)
            ADDR_FLAGS:    rd_d = flags_q;
            ADDR_MASK:     rd_d = mask_q;
            ADDR_CAP_LO:   rd_d = capture_q[7:0];
            ADDR_CAP_HI:   rd_d = temp_q;
            ADDR_CMP_A_LO: rd_d = compare_q[0][7:0];
            ADDR_CMP_A_HI: rd_d = compare_q[0][15:8];
            ADDR_CMP_B_LO: rd_d = compare_q[1][7:0];
            ADDR_CMP_B_HI: rd_d = compare_q[1][15:8];
            ADDR_CMP_C_LO: rd_d = compare_q[2][7:0];
            ADDR_CMP_C_HI: rd_d = compare_q[2][15:8];
            default:       rd_d = RESET_BYTE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rd_q <= RESET_BYTE;
        end else if (i_bus.rd) begin
            rd_q <= rd_d;
        end
    end

    assign o_rd_data     = rd_q;
    assign o_irq_request = irq_q;
    assign o_match_event = event_q;

    match_sets_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_timer_tick && !block_q && i_counter_value == compare_q[0])
        |=> flags_q[BIT_MATCH_A])
        else $error("match on channel A did not set its flag");

    force_no_flag_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_force_match[1] && !match_hit[1] && !flags_q[BIT_MATCH_B])
        |=> !flags_q[BIT_MATCH_B])
        else $error("forced compare set the channel B flag");

    match_irq_gate_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_irq_request[BIT_MATCH_C] |-> $past(mask_q[BIT_MATCH_C] && flags_q[BIT_MATCH_C]
                                            && i_global_irq_enable))
        else $error("channel C request without enable, global enable and flag");

    ovf_irq_gate_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (mask_q[BIT_OVERFLOW] && flags_q[BIT_OVERFLOW] && i_global_irq_enable)
        |=> o_irq_request[BIT_OVERFLOW])
        else $error("overflow request missing while enabled and flagged");

    vector_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_vector_ack[BIT_MATCH_B] && !match_hit[1]) |=> !flags_q[BIT_MATCH_B])
        else $error("channel B flag survived its vector");

    write_zero_keeps_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_bus.wr && i_bus.addr == ADDR_FLAGS && !i_bus.data[BIT_MATCH_A]
         && flags_q[BIT_MATCH_A] && !i_vector_ack[BIT_MATCH_A]) |=> flags_q[BIT_MATCH_A])
        else $error("writing zero cleared the channel A flag");

    write_one_clears_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_bus.wr && i_bus.addr == ADDR_FLAGS && i_bus.data[BIT_MATCH_C] && !match_hit[2])
        |=> !flags_q[BIT_MATCH_C])
        else $error("writing one did not clear the channel C flag");

    reserved_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
        ((flags_q & ~IRQ_BITS_MASK) == RESET_BYTE) && ((mask_q & ~IRQ_BITS_MASK) == RESET_BYTE))
        else $error("reserved interrupt bit is set");

    capture_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
        capture_q == RESET_WORD)
        else $error("capture value changed");

    counter_block_a: assert property (@(posedge i_clk) disable iff (i_rst)
        cnt_write |=> (match_hit == 3'b000))
        else $error("match taken on the tick after a counter write");

    compare_commit_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_bus.wr && i_bus.addr == ADDR_CMP_C_LO)
        |=> compare_q[2] == {$past(temp_q), $past(i_bus.data)})
        else $error("compare C low write did not commit both bytes");

    capture_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (cap_lo_read && !hi_write) |=> temp_q == $past(capture_q[15:8]))
        else $error("capture low read did not latch the high byte");

    overflow_sets_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_timer_tick && non_pwm && i_counter_value == COUNTER_MAX) |=> flags_q[BIT_OVERFLOW])
        else $error("overflow in a non-waveform mode did not set the flag");

    event_force_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_force_match[0] && non_pwm) |=> o_match_event[0])
        else $error("forced compare on channel A gave no compare event");

    event_match_a: assert property (@(posedge i_clk) disable iff (i_rst)
        match_hit[1] |=> o_match_event[1])
        else $error("match on channel B gave no compare event");

    mask_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_bus.wr && i_bus.addr == ADDR_MASK)
        |=> mask_q == ($past(i_bus.data) & IRQ_BITS_MASK))
        else $error("mask write did not store the implemented bits");

    no_global_irq_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_global_irq_enable |=> (o_irq_request == 4'h0))
        else $error("interrupt requested while globally disabled");

    request_flag_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_irq_request[BIT_MATCH_A] |-> $past(flags_q[BIT_MATCH_A]))
        else $error("channel A request without its flag");

    block_release_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (block_q && i_timer_tick && !cnt_write) |=> !block_q)
        else $error("match blocking outlived one timer tick");

    temp_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
        hi_write |=> temp_q == $past(i_bus.data))
        else $error("high byte write did not load the holding byte");

    match_vector_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_vector_ack[BIT_MATCH_A] && !match_hit[0]) |=> !flags_q[BIT_MATCH_A])
        else $error("channel A flag survived its vector");

    ovf_vector_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_vector_ack[BIT_OVERFLOW] && !overflow_hit) |=> !flags_q[BIT_OVERFLOW])
        else $error("overflow flag survived its vector");

    pwm_overflow_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_timer_tick && !non_pwm && i_pwm_overflow) |=> flags_q[BIT_OVERFLOW])
        else $error("overflow in a waveform mode did not set the flag");

endmodule

// file: cpu_vector_model.sv
`timescale 1ns/1ps
module cpu_vector_model (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_auto,
    input  wire logic [3:0] i_irq_request,
    output logic      [3:0] o_vector_ack
);
    logic [1:0] hold_q;

    // The core serves the pending vectors, then needs some cycles before it samples again.
    always_ff @(posedge i_clk) begin
        if (i_rst || !i_auto) begin
            o_vector_ack <= 4'h0;
            hold_q       <= 2'h0;
        end else if (hold_q != 2'h0) begin
            o_vector_ack <= 4'h0;
            hold_q       <= hold_q - 2'h1;
        end else begin
            o_vector_ack <= i_irq_request;
            hold_q       <= 2'h3;
        end
    end
endmodule

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import timer_irq_pkg::*;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    bus_req_type bus = '0;
    logic        tick = 1'b0;
    logic [15:0] cnt = 16'h0000;
    logic [3:0]  mode = 4'h0;
    logic        pwm = 1'b0;
    logic [2:0]  force_m = 3'h0;
    logic        gie = 1'b0;
    logic        auto_ack = 1'b0;
    logic [3:0]  ack;
    logic [7:0]  rd_data;
    logic [3:0]  irq;
    logic [2:0]  evt;
    int          err_count = 0;
    int          comparisons = 0;
    int          cycles = 0;

    always #12.5 clk = ~clk;

    timer_compare_irq_regs i_dut (
        .i_clk(clk), .i_rst(rst), .i_bus(bus), .i_timer_tick(tick),
        .i_counter_value(cnt), .i_waveform_mode_select(mode), .i_pwm_overflow(pwm),
        .i_force_match(force_m), .i_global_irq_enable(gie), .i_vector_ack(ack),
        .o_rd_data(rd_data), .o_irq_request(irq), .o_match_event(evt)
    );

    cpu_vector_model i_cpu (
        .i_clk(clk), .i_rst(rst), .i_auto(auto_ack), .i_irq_request(irq),
        .o_vector_ack(ack)
    );

    task automatic end_sim();
        if (err_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count = err_count + 1;
            end_sim();
        end
    end

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
        @(posedge clk);
        bus <= '0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
        @(posedge clk);
        bus <= '0;
        @(negedge clk);
        chk($sformatf("read_%h", a), exp, rd_data);
    endtask

    task automatic wr16(input logic [7:0] hi_addr, input logic [15:0] v);
        wr(hi_addr, v[15:8]);
        wr(hi_addr - 8'h01, v[7:0]);
    endtask

    task automatic step(input logic [15:0] v);
        @(posedge clk);
        tick <= 1'b1;
        cnt  <= v;
        @(posedge clk);
        tick <= 1'b0;
    endtask

    task automatic chk_irq(input logic [3:0] exp);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("irq_request", {4'h0, exp}, {4'h0, irq});
    endtask

    task automatic chk_evt(input logic [2:0] exp);
        @(negedge clk);
        chk("match_event", {5'h00, exp}, {5'h00, evt});
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd(ADDR_FLAGS, 8'h00);
        rd(ADDR_MASK, 8'h00);
        rd(ADDR_CAP_LO, 8'h00);
        rd(ADDR_CMP_C_LO, 8'h00);
        wr(ADDR_MASK, 8'hFF);
        rd(ADDR_MASK, 8'h2F);
        wr16(ADDR_CMP_A_HI, 16'h0100);
        wr16(ADDR_CMP_B_HI, 16'h0200);
        wr16(ADDR_CMP_C_HI, 16'h1234);
        rd(ADDR_CMP_C_LO, 8'h34);
        rd(ADDR_CMP_C_HI, 8'h12);
        step(16'h0100);
        chk_evt(3'h1);
        rd(ADDR_FLAGS, 8'h02);
        chk_irq(4'h0);
        @(posedge clk);
        force_m <= 3'h7;
        @(posedge clk);
        force_m <= 3'h0;
        chk_evt(3'h7);
        rd(ADDR_FLAGS, 8'h02);
        wr(ADDR_FLAGS, 8'h00);
        rd(ADDR_FLAGS, 8'h02);
        wr(ADDR_FLAGS, 8'h22);
        rd(ADDR_FLAGS, 8'h00);
        wr(ADDR_CNT_LO, 8'h00);
        step(16'h0200);
        rd(ADDR_FLAGS, 8'h00);
        step(16'h0200);
        rd(ADDR_FLAGS, 8'h04);
        step(16'h1234);
        step(COUNTER_MAX);
        step(16'h0100);
        rd(ADDR_FLAGS, 8'h0F);
        @(posedge clk);
        gie <= 1'b1;
        chk_irq(4'hF);
        wr(ADDR_MASK, 8'h20);
        chk_irq(4'h0);
        wr(ADDR_MASK, 8'h0F);
        auto_ack <= 1'b1;
        repeat (12) @(posedge clk);
        rd(ADDR_FLAGS, 8'h00);
        @(posedge clk);
        auto_ack <= 1'b0;
        mode <= 4'h1;
        step(COUNTER_MAX);
        rd(ADDR_FLAGS, 8'h00);
        @(posedge clk);
        pwm <= 1'b1;
        step(16'h0000);
        pwm <= 1'b0;
        rd(ADDR_FLAGS, 8'h01);
        wr(ADDR_FLAGS, 8'h01);
        mode <= MODE_CLEAR_A;
        step(COUNTER_MAX);
        rd(ADDR_FLAGS, 8'h01);
        wr(ADDR_FLAGS, 8'h01);
        mode <= MODE_CLEAR_B;
        step(COUNTER_MAX);
        rd(ADDR_FLAGS, 8'h01);
        wr(ADDR_CMP_C_HI, 8'h55);
        rd(ADDR_CAP_LO, 8'h00);
        rd(ADDR_CAP_HI, 8'h00);
        end_sim();
    end
endmodule
